// ---- reset_seq_pkg.sv ----
package reset_seq_pkg;

  // ---------------------------------------------------------------
  // nominal timing in ns and derived cycle counts
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int POR_NS           = 10000;
  localparam int STARTUP_REG_NS   = 20000;
  localparam int STARTUP_NOREG_NS = 64000000;
  localparam int RST_NS           = 20000;
  localparam int LOCK_NS          = 20000;
  localparam int MON_DLY_NS       = 500000;
  localparam int MON_DLY_ALT_NS   = 100000;  // shorter figure also quoted for the monitor delay

  // least times: round up to whole cycles
  localparam int POR_CYC           = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_REG_CYC   = (STARTUP_REG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_NOREG_CYC = (STARTUP_NOREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC           = (RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC          = (LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MON_DLY_CYC       = (MON_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MON_DLY_ALT_CYC   = (MON_DLY_ALT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W      = 20;
  localparam int OST_BITS     = 10;
  localparam int OST_PERIODS  = 1024;
  localparam int OSC_DEAD_CYC = 64;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int CTRL_REG_EN_BIT = 0;
  localparam int CTRL_MON_EN_BIT = 1;
  localparam int CTRL_SRC_LSB    = 2;
  localparam int STAT_CAUSE_LSB  = 5;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_EC          = 4'h0,
    SRC_FAST_RC     = 4'h1,
    SRC_LOW_RC      = 4'h2,
    SRC_EC_PLL      = 4'h3,
    SRC_FAST_RC_PLL = 4'h4,
    SRC_XT          = 4'h5,
    SRC_HS          = 4'h6,
    SRC_SEC_OSC     = 4'h7,
    SRC_XT_PLL      = 4'h8,
    SRC_HS_PLL      = 4'h9
  } clk_src_t;

  typedef enum logic [2:0] {
    CAUSE_POR    = 3'h0,
    CAUSE_PIN    = 3'h1,
    CAUSE_WDOG   = 3'h2,
    CAUSE_SW     = 3'h3,
    CAUSE_ILLOP  = 3'h4,
    CAUSE_UNINIT = 3'h5,
    CAUSE_TRAPC  = 3'h6
  } reset_cause_t;

  typedef struct packed {
    clk_src_t src;
    logic     monitor_en;
    logic     regulator_en;
  } cfg_t;

  typedef struct packed {
    logic watchdog;
    logic software;
    logic illegal_op;
    logic uninit_wreg;
    logic trap_conflict;
  } reset_req_t;

  typedef struct packed {
    reset_cause_t cause;
    logic         fallback;
    logic         monitor_active;
    logic         exec_en;
    logic         clk_released;
    logic         sys_released;
  } status_t;

  localparam cfg_t CTRL_RST = '{src: SRC_XT_PLL, monitor_en: 1'b1, regulator_en: 1'b1};

endpackage

// ---- delay_timer.sv ----
`timescale 1ns/100ps
// one-shot down counter: done pulses load cycles after start
module delay_timer #(
  parameter int W = 20
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_reg;

  // restart on start even while busy, so a new request extends the wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      cnt_reg <= load;
      busy    <= 1'b1;
      done    <= 1'b0;
    end else begin
      done <= busy && (cnt_reg == W'(1));
      if (busy) begin
        cnt_reg <= cnt_reg - W'(1);
        busy    <= (cnt_reg != W'(1));
      end
    end
  end

endmodule

// ---- reset_delay_sequencer.sv ----
`timescale 1ns/100ps
module reset_delay_sequencer
  import reset_seq_pkg::*;
#(
  parameter int STARTUP_NOREG_CYCLES = STARTUP_NOREG_CYC,
  parameter int MON_DLY_CYCLES       = MON_DLY_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               external_reset_pin_n,
  input  wire logic               osc_in,
  input  wire reset_seq_pkg::reset_req_t reset_req,
  input  wire logic               wake_req,
  input  wire logic [7:0]         addr,
  input  wire logic [15:0]        wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic [15:0]             rd_data,
  output logic                    system_reset_release,
  output logic                    clk_released,
  output logic                    exec_en,
  output logic                    use_fast_internal_rc,
  output logic                    monitor_active,
  output logic                    monitor_trap
);
  import reset_seq_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic       rst_meta_reg, rst_sync_n;
  logic [1:0] pin_sync_reg;
  logic [1:0] osc_sync_reg;
  logic       osc_last_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // pins only reach logic through their second flop
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_sync_reg <= 2'b11;
      osc_sync_reg <= 2'b00;
      osc_last_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], external_reset_pin_n};
      osc_sync_reg <= {osc_sync_reg[0], osc_in};
      osc_last_reg <= osc_sync_reg[1];
    end
  end

  wire osc_edge = osc_sync_reg[1] && !osc_last_reg;
  wire pin_rst  = !pin_sync_reg[1];

  // ---------------------------------------------------------------
  // configuration and source decode
  // ---------------------------------------------------------------
  cfg_t cfg_reg;

  wire needs_ost = (cfg_reg.src == SRC_XT) || (cfg_reg.src == SRC_HS) ||
                   (cfg_reg.src == SRC_SEC_OSC) || (cfg_reg.src == SRC_XT_PLL) ||
                   (cfg_reg.src == SRC_HS_PLL);
  wire needs_pll = (cfg_reg.src == SRC_EC_PLL) || (cfg_reg.src == SRC_FAST_RC_PLL) ||
                   (cfg_reg.src == SRC_XT_PLL) || (cfg_reg.src == SRC_HS_PLL);
  wire needs_mon_delay = needs_ost || needs_pll;
  wire ctrl_wr   = wr_en && (addr == CTRL_OFS);
  wire any_req   = pin_rst || reset_req.watchdog || reset_req.software ||
                   reset_req.illegal_op || reset_req.uninit_wreg ||
                   reset_req.trap_conflict;

  // highest-numbered request source is reported when several coincide
  reset_cause_t req_cause;
  assign req_cause = reset_req.trap_conflict ? CAUSE_TRAPC :
                     reset_req.uninit_wreg   ? CAUSE_UNINIT :
                     reset_req.illegal_op    ? CAUSE_ILLOP :
                     reset_req.software      ? CAUSE_SW :
                     reset_req.watchdog      ? CAUSE_WDOG : CAUSE_PIN;

  // ---------------------------------------------------------------
  // reset release sequence
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    S_BOOT  = 6'b000001,
    S_POR   = 6'b000010,
    S_START = 6'b000100,
    S_RST   = 6'b001000,
    S_RUN   = 6'b010000,
    S_WAKE  = 6'b100000
  } seq_state_t;

  seq_state_t   seq_reg, seq_next;
  logic         seq_start, seq_done;
  logic [TIMER_W-1:0] seq_load;
  reset_cause_t cause_reg;

  wire [TIMER_W-1:0] startup_load = cfg_reg.regulator_en ?
                     TIMER_W'(STARTUP_REG_CYC) : TIMER_W'(STARTUP_NOREG_CYCLES);

  // every release-sequence delay is a cycle count on clk_sys; only the clock path counts edges of the awaited source
  always_comb begin
    seq_next  = seq_reg;
    seq_start = 1'b0;
    seq_load  = TIMER_W'(RST_CYC);
    case (seq_reg)
      S_BOOT: begin
        seq_start = 1'b1;
        seq_load  = TIMER_W'(POR_CYC);
        seq_next  = S_POR;
      end
      S_POR: if (seq_done) begin
        seq_start = 1'b1;
        seq_load  = startup_load;
        seq_next  = S_START;
      end
      S_START: if (seq_done) begin
        seq_start = 1'b1;
        seq_next  = S_RST;
      end
      S_RST: if (any_req) begin
        seq_start = 1'b1;
      end else if (seq_done) begin
        seq_next  = S_RUN;
      end
      S_RUN: if (any_req) begin
        seq_start = 1'b1;
        seq_next  = S_RST;
      end else if (wake_req && cfg_reg.regulator_en) begin
        seq_start = 1'b1;
        seq_load  = TIMER_W'(STARTUP_REG_CYC);
        seq_next  = S_WAKE;
      end
      S_WAKE: if (any_req) begin
        seq_start = 1'b1;
        seq_next  = S_RST;
      end else if (seq_done) begin
        seq_next  = S_RUN;
      end
      default: seq_next = S_BOOT;
    endcase
  end

  delay_timer #(.W(TIMER_W)) u_seq_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .start   (seq_start),
    .load    (seq_load),
    .busy    (),
    .done    (seq_done)
  );

  // ---------------------------------------------------------------
  // clock path: oscillator start-up and pll lock
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    C_IDLE  = 4'b0001,
    C_OST   = 4'b0010,
    C_LOCK  = 4'b0100,
    C_READY = 4'b1000
  } clk_state_t;

  clk_state_t        clk_reg, clk_next;
  logic [OST_BITS-1:0] ost_reg;
  logic              lock_start, lock_done;

  // runs on its own from boot; reset requests never touch it
  always_comb begin
    clk_next   = clk_reg;
    lock_start = 1'b0;
    case (clk_reg)
      C_IDLE: begin
        if (needs_ost) begin
          clk_next = C_OST;
        end else if (needs_pll) begin
          lock_start = 1'b1;
          clk_next   = C_LOCK;
        end else begin
          clk_next = C_READY;
        end
      end
      C_OST: if (osc_edge && (ost_reg == OST_BITS'(OST_PERIODS - 1))) begin
        lock_start = needs_pll;
        clk_next   = needs_pll ? C_LOCK : C_READY;
      end
      C_LOCK:  if (lock_done) clk_next = C_READY;
      C_READY: clk_next = C_READY;
      default: clk_next = C_IDLE;
    endcase
    if (ctrl_wr && (clk_reg != C_IDLE)) begin
      clk_next   = C_IDLE;
      lock_start = 1'b0;
    end
  end

  delay_timer #(.W(TIMER_W)) u_lock_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .start   (lock_start),
    .load    (TIMER_W'(LOCK_CYC)),
    .busy    (),
    .done    (lock_done)
  );

  // ---------------------------------------------------------------
  // fail-safe clock monitor
  // ---------------------------------------------------------------
  logic        mon_delay_done_reg;
  logic        fallback_reg;
  logic [7:0]  dead_cnt_reg;
  logic        mon_start, mon_done;

  wire mon_begin_ok = seq_reg == S_START && seq_done;
  assign mon_start  = mon_begin_ok && needs_mon_delay;
  wire osc_dead     = dead_cnt_reg == 8'(OSC_DEAD_CYC);
  wire clk_valid    = (clk_reg == C_READY) && !((needs_ost) && osc_dead);
  wire mon_go       = cfg_reg.monitor_en && mon_delay_done_reg &&
                      system_reset_release;
  wire mon_fail     = mon_go && !clk_valid && !fallback_reg;

  delay_timer #(.W(TIMER_W)) u_mon_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .start   (mon_start),
    .load    (TIMER_W'(MON_DLY_CYCLES)),
    .busy    (),
    .done    (mon_done)
  );

  // activity watch on the oscillator pin; saturates when it stalls
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dead_cnt_reg <= 8'h00;
    end else if (osc_edge) begin
      dead_cnt_reg <= 8'h00;
    end else if (!osc_dead) begin
      dead_cnt_reg <= dead_cnt_reg + 8'h01;
    end
  end

  // monitor gate and fallback; a new failure wins over a clear
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mon_delay_done_reg <= 1'b0;
      fallback_reg       <= 1'b0;
    end else begin
      if (mon_done || (mon_begin_ok && !needs_mon_delay)) begin
        mon_delay_done_reg <= 1'b1;
      end
      if (mon_fail) begin
        fallback_reg <= 1'b1;
      end else if (clk_reg == C_READY && clk_valid) begin
        fallback_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // state registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_reg   <= S_BOOT;
      clk_reg   <= C_IDLE;
      ost_reg   <= '0;
      cause_reg <= CAUSE_POR;
    end else begin
      seq_reg <= seq_next;
      clk_reg <= clk_next;
      if (clk_reg != C_OST) begin
        ost_reg <= '0;
      end else if (osc_edge) begin
        ost_reg <= ost_reg + OST_BITS'(1);
      end
      if (any_req) begin
        cause_reg <= req_cause;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      system_reset_release <= 1'b0;
      clk_released         <= 1'b0;
      exec_en              <= 1'b0;
      use_fast_internal_rc <= 1'b0;
      monitor_active       <= 1'b0;
      monitor_trap         <= 1'b0;
    end else begin
      system_reset_release <= (seq_next == S_RUN) || (seq_next == S_WAKE);
      clk_released         <= clk_valid || fallback_reg || mon_fail;
      exec_en              <= (seq_next == S_RUN) && (clk_valid || fallback_reg);
      use_fast_internal_rc <= fallback_reg || mon_fail;
      monitor_active       <= mon_go;
      monitor_trap         <= mon_fail;
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  status_t status;
  assign status = '{cause: cause_reg, fallback: use_fast_internal_rc,
                    monitor_active: monitor_active, exec_en: exec_en,
                    clk_released: clk_released, sys_released: system_reset_release};

  wire [15:0] rd_mux = (addr == CTRL_OFS)   ? {10'h000, cfg_reg} :
                       (addr == STATUS_OFS) ? {8'h00, status} : 16'h0000;

  // source change restarts the clock path; reset value is the boot source
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_reg <= CTRL_RST;
      rd_data <= 16'h0000;
    end else begin
      if (ctrl_wr) begin
        cfg_reg <= cfg_t'(wr_data[5:0]);
      end
      rd_data <= rd_en ? rd_mux : 16'h0000;
    end
  end

endmodule

// ---- osc_source.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// crystal beside the sequencer
// ------------------------------------------------------------
// runs free while enabled; a dead crystal stops at its last level
module osc_source #(
  parameter int HALF_NS = 130
) (
  input  wire logic run,
  output logic      osc_out
);
  // oscillation, never phase locked to the reference clock
  initial osc_out = 1'b0;
  always begin
    #(HALF_NS);
    if (run) osc_out = ~osc_out; // stall leaves no clock to monitor
  end
endmodule

// ---- reset_delay_sequencer_asserts.sv ----
`timescale 1ns/100ps
module reset_delay_sequencer_asserts #(
  parameter int STARTUP_NOREG_CYCLES = 300,
  parameter int MON_DLY_CYCLES       = 50
) (
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire logic                      osc_in,
  input wire reset_seq_pkg::reset_req_t reset_req,
  input wire logic                      wake_req,
  input wire logic [7:0]                addr,
  input wire logic [15:0]               wr_data,
  input wire logic                      wr_en,
  input wire logic                      system_reset_release,
  input wire logic                      clk_released,
  input wire logic                      exec_en,
  input wire logic                      use_fast_internal_rc,
  input wire logic                      monitor_active,
  input wire logic                      monitor_trap
);
  import reset_seq_pkg::*;
  localparam int POR_HOLD = POR_CYC + STARTUP_REG_CYC + RST_CYC;

  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic [11:0] low_cnt_reg;
  logic [11:0] edge_cnt_reg;
  logic [11:0] wr_cnt_reg;
  logic        por_reg;
  logic        osc_d_reg;
  clk_src_t    src_reg;
  wire         ctrl_wr  = wr_en && (addr == CTRL_OFS);
  wire         osc_rise = osc_in && !osc_d_reg;
  wire         xtal_src = src_reg inside {SRC_XT, SRC_HS, SRC_SEC_OSC, SRC_XT_PLL, SRC_HS_PLL};
  wire         pll_src  = src_reg inside {SRC_EC_PLL, SRC_FAST_RC_PLL, SRC_XT_PLL, SRC_HS_PLL};

  // saturating, so a long idle cannot wrap into a false pass
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg  <= '0;
      edge_cnt_reg <= '0;
      wr_cnt_reg   <= '0;
      por_reg      <= 1'b1;
      osc_d_reg    <= 1'b0;
      src_reg      <= CTRL_RST.src;
    end else begin
      low_cnt_reg  <= system_reset_release ? '0 : low_cnt_reg + 12'(~&low_cnt_reg);
      edge_cnt_reg <= ctrl_wr ? '0 : edge_cnt_reg + 12'(osc_rise && !(&edge_cnt_reg));
      wr_cnt_reg   <= ctrl_wr ? '0 : wr_cnt_reg + 12'(~&wr_cnt_reg);
      por_reg      <= por_reg && !system_reset_release;
      osc_d_reg    <= osc_in;
      if (ctrl_wr) src_reg <= clk_src_t'(wr_data[5:2]);
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_power_on_hold: assert property (
    $rose(system_reset_release) && por_reg |-> low_cnt_reg >= POR_HOLD)
    else $error("release came early after power-on");
  a_internal_hold: assert property (
    $rose(system_reset_release) |-> low_cnt_reg >= RST_CYC)
    else $error("release came early after a reset request");
  a_request_drops: assert property (
    reset_req != '0 |-> ##2 !system_reset_release)
    else $error("reset request did not hold the system");
  a_wake_keeps: assert property (
    wake_req && system_reset_release && reset_req == '0 |=> system_reset_release)
    else $error("wake dropped the reset release");
  a_exec_gated: assert property (
    exec_en |-> clk_released && system_reset_release)
    else $error("execution without a released clock");
  a_monitor_start: assert property (
    $rose(monitor_active) || monitor_trap |-> system_reset_release)
    else $error("monitor acted before reset release");
  a_trap_fallback: assert property (
    monitor_trap |-> ##[0:1] (use_fast_internal_rc && clk_released) ##1 !monitor_trap)
    else $error("trap without fallback clock");
  a_fallback_clock: assert property (
    use_fast_internal_rc |-> clk_released)
    else $error("fallback clock not released");
  // two oscillator periods of slack for the oscillator synchroniser at restart
  a_ost_count: assert property (
    $fell(use_fast_internal_rc) && xtal_src |-> edge_cnt_reg >= OST_PERIODS - 2)
    else $error("crystal released before its start-up count");
  a_lock_wait: assert property (
    $fell(use_fast_internal_rc) && pll_src |-> wr_cnt_reg >= LOCK_CYC)
    else $error("pll clock released before lock time");
endmodule

bind reset_delay_sequencer reset_delay_sequencer_asserts #(
  .STARTUP_NOREG_CYCLES(STARTUP_NOREG_CYCLES),
  .MON_DLY_CYCLES      (MON_DLY_CYCLES)
) u_asserts (
  .clk_sys             (clk_sys),
  .rst_n               (rst_n),
  .osc_in              (osc_in),
  .reset_req           (reset_req),
  .wake_req            (wake_req),
  .addr                (addr),
  .wr_data             (wr_data),
  .wr_en               (wr_en),
  .system_reset_release(system_reset_release),
  .clk_released        (clk_released),
  .exec_en             (exec_en),
  .use_fast_internal_rc(use_fast_internal_rc),
  .monitor_active      (monitor_active),
  .monitor_trap        (monitor_trap)
);

// ---- reset_delay_sequencer_test.sv ----
`timescale 1ns/100ps
module reset_delay_sequencer_test;
  import reset_seq_pkg::*;
  // ------------------------------------------------------------
  // bench signals and model state
  // ------------------------------------------------------------
  localparam int HALF = 130;  // osc half period, ns
  localparam int OSC_CY = 2 * HALF * OST_PERIODS / CLK_PERIOD_NS;
  localparam int POR_HOLD = POR_CYC + STARTUP_REG_CYC + RST_CYC;
  localparam int NOREG = 300;  // short unregulated start-up count for the bench
  logic        clk_sys = 1'b0;
  logic        rst_n, external_reset_pin_n, osc_run, osc_in, wake_req;
  reset_req_t  reset_req;
  logic [7:0]  addr, a;
  logic [15:0] wr_data, rd_data, d;
  logic        wr_en, rd_en, system_reset_release, clk_released, exec_en;
  logic        use_fast_internal_rc, monitor_active, monitor_trap;
  int          err_count, samples_checked, ctrl_model, m, n, k;
  int          cause_q[$] = '{2, 3, 4, 5, 6, 1};  // expected cause per request

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  osc_source #(.HALF_NS(HALF)) u_osc (.run(osc_run), .osc_out(osc_in));

  // short counts keep the run brief
  reset_delay_sequencer #(.STARTUP_NOREG_CYCLES(NOREG), .MON_DLY_CYCLES(50)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .external_reset_pin_n(external_reset_pin_n),
    .osc_in(osc_in), .reset_req(reset_req), .wake_req(wake_req), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .system_reset_release(system_reset_release), .clk_released(clk_released),
    .exec_en(exec_en), .use_fast_internal_rc(use_fast_internal_rc),
    .monitor_active(monitor_active), .monitor_trap(monitor_trap));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a range is reported against its lower bound
  task automatic span(string what, int got, int lo, int hi);
    check(what, 16'(got), (got >= lo && got <= hi) ? 16'(got) : 16'(lo));
  endtask

  task automatic wr(logic [7:0] wa, logic [15:0] v);
    @(posedge clk_sys);
    addr <= wa;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    if (wa == CTRL_OFS) ctrl_model = v & 16'h3F;
  endtask

  task automatic rd(logic [7:0] ra, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= ra;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  // bounded wait for a level, counting clock cycles
  task automatic wait_lvl(ref logic s, input logic lvl, output int cnt);
    cnt = 0;
    while (s !== lvl && cnt < 5000) begin
      @(posedge clk_sys);
      #1 cnt++;
    end
  endtask

  // power-on with default setup: crystal and pll cannot be ready at release
  task automatic power_on(input bit noreg);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    ctrl_model = 16'(CTRL_RST);
    k = POR_HOLD;
    // regulator off before the power-on delay ends: long start-up, 5 edges spent
    if (noreg) begin
      repeat (3) @(posedge clk_sys);
      wr(CTRL_OFS, 16'h22);
      k = POR_HOLD + NOREG - STARTUP_REG_CYC - 5;
    end
    #1 wait_lvl(system_reset_release, 1'b1, n);
    span("por_len", n, k, k + 8);
    wait_lvl(monitor_trap, 1'b1, n);
    span("trap_lag", n, 0, 3);
    @(posedge clk_sys);
    #1 check("fallback", 16'({use_fast_internal_rc, clk_released, exec_en}), 16'h7);
    rd(STATUS_OFS, d);
    check("status_por", d, 16'h001F);
    rd(CTRL_OFS, d);
    check("ctrl_reset", d, 16'(ctrl_model));
  endtask

  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h7b8c8a97));
    {external_reset_pin_n, osc_run} = 2'b11;
    {wake_req, wr_en, rd_en, addr, wr_data} = '0;
    reset_req = '0;
    power_on(1'b0);
    // unmapped place: reads zero, keeps control intact
    a = 8'h08 | 8'($urandom);
    wr(a, 16'($urandom));
    rd(a, d);
    check("unmapped", d, 16'h0000);
    rd(CTRL_OFS, d);
    check("ctrl_kept", d, 16'(ctrl_model));
    // crystal with pll: start-up count then lock, monitor off
    wr(CTRL_OFS, 16'h21);
    wait_lvl(use_fast_internal_rc, 1'b0, n);
    span("crystal_xt_with_pll_ready", n, OSC_CY + LOCK_CYC - 3, OSC_CY + LOCK_CYC + 12);
    // each source restarts the clock path: crystal adds 1024 periods, pll the lock time
    for (int s = 0; s < 10; s++) begin
      wr(CTRL_OFS, 16'((s << 2) | 1));
      k = ((s >= 5) ? OSC_CY : 2) + ((s == 3 || s == 4 || s >= 8) ? LOCK_CYC + 1 : 0);
      #1 wait_lvl(clk_released, 1'b0, m);
      wait_lvl(clk_released, 1'b1, n);
      span("src_wait", m + n, k, k + 8);
      rd(CTRL_OFS, d);
      check("ctrl_src", d, 16'(ctrl_model));
    end
    wr(CTRL_OFS, 16'h05);
    foreach (cause_q[i]) begin
      k = 1 + $urandom % 3;
      @(posedge clk_sys);
      if (cause_q[i] == 1) external_reset_pin_n <= 1'b0;
      else reset_req <= reset_req_t'(5'h10 >> (cause_q[i] - 2));
      repeat (k) @(posedge clk_sys);
      external_reset_pin_n <= 1'b1;
      reset_req <= '0;
      #1 wait_lvl(system_reset_release, 1'b0, m);
      wait_lvl(system_reset_release, 1'b1, n);
      span("rst_len", m + n, RST_CYC, RST_CYC + 8);
      rd(STATUS_OFS, d);
      check("status_rst", d, 16'((cause_q[i] << 5) | 7));
    end
    // wake with regulator on waits the start-up delay, off does not
    for (int r = 1; r >= 0; r--) begin
      wr(CTRL_OFS, 16'(4 | r));
      repeat (5) @(posedge clk_sys);
      wake_req <= 1'b1;
      @(posedge clk_sys);
      wake_req <= 1'b0;
      #1 wait_lvl(exec_en, 1'b0, m);
      if (r == 1) wait_lvl(exec_en, 1'b1, n);
      if (r == 1) span("wake_len", m + n, STARTUP_REG_CYC, STARTUP_REG_CYC + 6);
      else check("wake_off", 16'(m), 16'd5000);
      check("wake_rel", 16'(system_reset_release), 16'h1);
    end
    // second power-on mid-run with the crystal dead
    osc_run <= 1'b0;
    power_on(1'b1);
    summarize();
  end

  // watchdog well beyond the expected run length
  initial begin
    #(CLK_PERIOD_NS * 40000);
    err_count++;
    summarize();
  end
endmodule
